// ==== design/aecr_device.sv ====
// Purpose: Extended-control register bank of the converter
// Assumes: Serial link sampled by the 40 MHz clock
// Notes:   Settings stay through power down; srst or normal mode (ext_mode low) restores them
//
// Behaviour
// RULE1: Gain from nine-bit field, powers up 100000000
// RULE2: Host keeps gain within recommended range; here out-of-range gain is still sent and sets ST_GAIN_WARN
// RULE3: Gain write never starts recalibration
// RULE4: Host writes ones to unused low bits
// RULE5: Fine phase field bits 15:7, reset zero
// RULE6: Coarse phase four bits 14:11, 70ps steps
// RULE7: Phase adjust applies only when enable set
// RULE8: Slow sample clock mode bit 10
// RULE9: Host sets trim-off with phase enable
// RULE10: Buffer depth field bits 15:14, resets 11
// RULE11: Depth codes 512, 1024, 2048, 4096 bytes
// RULE12: Stop when full, else overwrite oldest
// RULE13: Dual port bit enables second port
// RULE14: Pattern bit swaps converter for generator
// RULE15: Overrange high during pattern until empty
// RULE16: Sync reset source chosen by config bit
// RULE17: Sync reset asserted at any time
// RULE18: Resync sampling after sync reset release
// RULE19: Host holds sync reset minimum width
// RULE20: Write-only, kept, idle in normal mode; here normal mode resets them to defaults
// RULE21: Host stays off link during calibration
// RULE22: Settings change only after whole frame
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module aecr_device
	import aecr_pkg::*;
#(
	parameter int PTR_W = 12
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             ext_mode,          // Extended control mode
	input  wire logic             cal_active,        // Calibration running
	input  wire logic             capture_enable,    // Capture write enable
	input  wire logic             full_clear,        // Clears full flag
	input  wire logic             buffer_empty_flag, // Buffer read out
	input  wire logic [7:0]       converter_data,    // Live converter sample
	input  wire logic [7:0]       pattern_data,      // Test pattern sample
	aecr_link_if.device           link,
	output logic [8:0]            gain_code,
	output logic [8:0]            fine_delay,
	output logic [3:0]            coarse_delay_steps,
	output logic                  phase_adjust_on,
	output logic                  slow_sample_clock_mode,
	output logic                  diff_sync_reset_select,
	output logic                  termination_trim_off,
	output logic [1:0]            buffer_depth_select,
	output logic [12:0]           buffer_depth_bytes,
	output logic                  stop_when_full,
	output logic                  dual_port_output,
	output logic                  pattern_generator_on,
	output logic [7:0]            capture_data,      // Byte into the buffer
	output logic                  capture_write,     // Buffer write strobe
	output logic [PTR_W-1:0]      capture_addr,
	output logic                  buffer_full_flag,
	output logic                  out_of_range,
	output logic                  sampling_held,     // Sync reset in force
	output logic                  sampling_resync,   // One-cycle realign pulse
	output logic                  recal_request      // Never raised by writes
);
	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]  sclk_s, cs_s, sd_s, se_s, df_s;  // Pin synchronisers
		logic        sclk_f, cs_f, sd_f, se_f, df_f;  // Agreed pin levels
		logic [5:0]  nbit;
		logic [30:0] sh;
		logic [8:0]  gain, fine;
		logic [3:0]  steps;
		logic        pa_on, slow, diff, trim;
		logic [1:0]  depth;
		logic        stop, dual, pat;
		logic [PTR_W-1:0] wptr;
		logic        full, wr, ovr, held, resync;
		logic [7:0]  cdata;
	} aecr_dreg_t;
	aecr_dreg_t r, n;          // Current and next state
	logic [31:0] word;         // Completed frame
	logic        rise;         // Serial clock rising edge
	logic        rst_sel;      // Selected sync reset level
	logic [12:0] depth_b;      // Active depth in bytes

	// ----------------------------------------
	// Outputs, all but cal_busy and recal_request from the state record
	// ----------------------------------------
	assign link.cal_busy          = cal_active;
	assign recal_request          = 1'b0; // RULE3
	assign gain_code              = r.gain;
	assign fine_delay             = r.pa_on ? r.fine : FINE_POR; // RULE7
	assign coarse_delay_steps     = r.pa_on ? r.steps : STEP_POR; // RULE7
	assign phase_adjust_on        = r.pa_on;
	assign slow_sample_clock_mode = r.slow;
	assign diff_sync_reset_select = r.diff;
	assign termination_trim_off   = r.trim;
	assign buffer_depth_select    = r.depth;
	assign stop_when_full         = r.stop;
	assign dual_port_output       = r.dual;
	assign pattern_generator_on   = r.pat;
	assign buffer_depth_bytes     = depth_b;
	assign capture_data           = r.cdata;
	assign capture_write          = r.wr;
	assign capture_addr           = r.wptr;
	assign buffer_full_flag       = r.full;
	assign out_of_range           = r.ovr;
	assign sampling_held          = r.held;
	assign sampling_resync        = r.resync;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		n = r;
		// Three-stage synchronisers; a level counts once stages two and three agree
		n.sclk_s = {r.sclk_s[1:0], link.sclk};
		n.cs_s   = {r.cs_s[1:0], link.scs_n};
		n.sd_s   = {r.sd_s[1:0], link.sdata};
		n.se_s   = {r.se_s[1:0], link.sync_rst_se};
		n.df_s   = {r.df_s[1:0], link.sync_rst_diff};
		if (r.sclk_s[1] == r.sclk_s[2]) n.sclk_f = r.sclk_s[2];
		if (r.cs_s[1] == r.cs_s[2]) n.cs_f = r.cs_s[2];
		if (r.sd_s[1] == r.sd_s[2]) n.sd_f = r.sd_s[2];
		if (r.se_s[1] == r.se_s[2]) n.se_f = r.se_s[2];
		if (r.df_s[1] == r.df_s[2]) n.df_f = r.df_s[2];
		rise = n.sclk_f && !r.sclk_f;
		word = {r.sh, n.sd_f};

		// Serial frame: deselect aborts a partial frame
		if (n.cs_f) begin
			n.nbit = 6'h00; // RULE22
		end else if (rise) begin
			n.sh   = word[30:0];
			n.nbit = r.nbit + 6'h01;
			if (r.nbit == LAST_BIT) begin
				n.nbit = 6'h00;
				// Commit only a whole frame with a good header
				if (word[31:20] == FRAME_HDR) begin // RULE22
					unique case (word[19:16])
						REG_GAIN: n.gain = word[15:VAL_LSB]; // RULE1
						REG_FINE: n.fine = word[15:VAL_LSB]; // RULE5
						REG_COARSE: begin
							n.pa_on = word[PA_ON_BIT]; // RULE7
							n.steps = word[14:STEP_LSB]; // RULE6
							n.slow  = word[SLOW_BIT]; // RULE8
						end
						REG_BUFFER: begin
							n.depth = word[15:DEPTH_LSB]; // RULE10
							n.stop  = word[STOP_BIT]; // RULE12
							n.dual  = word[DUAL_BIT]; // RULE13
							n.pat   = word[PAT_BIT]; // RULE14
						end
						REG_CONFIG: begin
							n.diff = word[DIFF_BIT]; // RULE16
							n.trim = word[TRIM_BIT];
						end
						default: begin
						end
					endcase
				end
			end
		end

		// Normal mode: defaults forced, stored values dropped
		if (!ext_mode) begin // RULE20
			n.gain  = GAIN_POR;
			n.fine  = FINE_POR;
			n.steps = STEP_POR;
			n.pa_on = 1'b0;
			n.slow  = 1'b0;
			n.diff  = 1'b0;
			n.trim  = 1'b0;
			n.depth = DEPTH_POR;
			n.stop  = 1'b1;
			n.dual  = 1'b0;
			n.pat   = 1'b0;
		end

		// Depth from select code
		depth_b = DEPTH_BASE << r.depth; // RULE11

		// Capture: pattern replaces converter data
		n.cdata = r.pat ? pattern_data : converter_data; // RULE14
		n.wr    = 1'b0;
		// Auto-stop also holds in the wrap cycle, so the oldest byte is never overwritten
		if (capture_enable && !(r.stop && (r.full || (r.wr && r.wptr == '0)))) begin // RULE12
			n.wr   = 1'b1;
			n.wptr = r.wptr + 1'b1;
			if ({1'b0, r.wptr} == depth_b - 13'h0001) begin
				n.wptr = '0; // RULE12
			end
		end
		if (!capture_enable) begin
			n.wptr = '0;
		end
		// Full flag: set wins over clear
		if (full_clear) n.full = 1'b0;
		if (r.wr && r.wptr == '0) begin
			n.full = 1'b1;
		end

		// Overrange output during pattern until buffer empties
		if (!r.pat || buffer_empty_flag) begin
			n.ovr = 1'b0; // RULE15
		end else if (r.wr) begin
			n.ovr = 1'b1;
		end
		if (n.pat && !r.pat) n.ovr = 1'b1; // RULE15

		// Sync reset: any-time assertion, realign on release
		rst_sel  = r.diff ? r.df_f : r.se_f; // RULE16
		n.held   = rst_sel; // RULE17
		n.resync = r.held && !rst_sel; // RULE18
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= '{gain: GAIN_POR, depth: DEPTH_POR, stop: 1'b1,
				sclk_s: 3'h0, cs_s: 3'h7, sd_s: 3'h0, cs_f: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end
endmodule
`default_nettype wire

// ==== design/aecr_pkg.sv ====
// Purpose: Shared constants for the extended-control register link
// Assumes: 40 MHz system clock on both ends
// Notes:   Register data words are 16 bits, frames 32 bits
package aecr_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [3:0] REG_CONFIG = 4'h1;
	localparam logic [3:0] REG_GAIN   = 4'h3;
	localparam logic [3:0] REG_FINE   = 4'hd;
	localparam logic [3:0] REG_COARSE = 4'he;
	localparam logic [3:0] REG_BUFFER = 4'hf;
	// ----------------------------------------
	// Frame layout: header, address, data
	// ----------------------------------------
	localparam int         FRAME_BITS = 32;
	localparam logic [5:0] LAST_BIT   = 6'h1f;
	localparam logic [11:0] FRAME_HDR = 12'h001;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         VAL_LSB     = 7;
	localparam int         PA_ON_BIT   = 15;
	localparam int         STEP_LSB    = 11;
	localparam int         SLOW_BIT    = 10;
	localparam int         DEPTH_LSB   = 14;
	localparam int         STOP_BIT    = 13;
	localparam int         DUAL_BIT    = 12;
	localparam int         PAT_BIT     = 11;
	localparam int         DIFF_BIT    = 14;
	localparam int         TRIM_BIT    = 13;
	localparam logic [8:0] GAIN_POR    = 9'h100;
	localparam logic [8:0] FINE_POR    = 9'h000;
	localparam logic [3:0] STEP_POR    = 4'h0;
	localparam logic [1:0] DEPTH_POR   = 2'h3;
	localparam logic [8:0] GAIN_REC_LO = 9'h0c0;
	localparam logic [8:0] GAIN_REC_HI = 9'h1c0;
	localparam logic [15:0] ONES_VAL    = 16'h007f;
	localparam logic [15:0] ONES_COARSE = 16'h03ff;
	localparam logic [15:0] ONES_BUFFER = 16'h07ff;
	localparam logic [15:0] CFG_FIXED   = 16'h82ff;
	// ----------------------------------------
	// Capture buffer depth: 512 bytes shifted by the select code
	// ----------------------------------------
	localparam logic [12:0] DEPTH_BASE = 13'h0200;
	// ----------------------------------------
	// Host APB map
	// ----------------------------------------
	localparam logic [7:0] HOST_CMD    = 8'h00;
	localparam logic [7:0] HOST_CTRL   = 8'h04;
	localparam logic [7:0] HOST_STATUS = 8'h08;
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_GAIN_WARN = 2;
	localparam int ST_CAL = 3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 25;
	localparam int SCLK_PERIOD_NS = 200;
	localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int SYNC_RST_NS    = 100;
	localparam int SYNC_RST_CYC   = (SYNC_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== design/aecr_link_if.sv ====
// Purpose: Serial control link between host and converter
// Assumes: Host makes the serial clock
// Notes:   All pins one-way
`timescale 1ns/1ps
`default_nettype none
interface aecr_link_if;
	logic sclk;            // Serial clock from host
	logic scs_n;           // Frame select, active low
	logic sdata;           // Serial data, host to device
	logic cal_busy;        // Calibration in progress
	logic sync_rst_se;     // Single-ended sampling sync reset
	logic sync_rst_diff;   // Differential sampling sync reset
	// Device end
	modport device (input sclk, input scs_n, input sdata, input sync_rst_se,
		input sync_rst_diff, output cal_busy);
	// Host end
	modport host (output sclk, output scs_n, output sdata, output sync_rst_se,
		output sync_rst_diff, input cal_busy);
endinterface
`default_nettype wire

// ==== design/aecr_host.sv ====
// Purpose: Host controller writing the extended registers over the link
// Assumes: APB slave with zero wait states
// Notes:   Frame is header, address, data, MSB first
`timescale 1ns/1ps
`default_nettype none
module aecr_host
	import aecr_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC,
	parameter int RST_CYC  = SYNC_RST_CYC
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	aecr_link_if.host        link
);
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01, H_SHIFT = 2'b10} aecr_hst_t;
	typedef struct packed {
		aecr_hst_t   st;
		logic [7:0]  div;
		logic [5:0]  nbit;
		logic [31:0] sh;
		logic        sclk, cs_n;
		logic [2:0]  cal_s;
		logic        cal_f;
		logic [19:0] cmd;
		logic        refused, gwarn;
		logic        pa_on, trim, diff;
		logic [7:0]  rcnt;
		logic [31:0] rd;
	} aecr_hreg_t;
	aecr_hreg_t r, n;               // Current and next state
	logic wr_acc;                   // Write access phase
	logic [15:0] d;                 // Outgoing data word
	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr == HOST_CMD || paddr == HOST_CTRL || paddr == HOST_STATUS);
	assign prdata  = r.rd;
	assign wr_acc  = psel && penable && pwrite;
	assign link.sclk  = r.sclk;
	assign link.scs_n = r.cs_n;
	assign link.sdata = r.sh[31];
	assign link.sync_rst_se   = (r.rcnt != 8'h00) && !r.diff;
	assign link.sync_rst_diff = (r.rcnt != 8'h00) && r.diff;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		d = pwdata[15:0];
		n.cal_s = {r.cal_s[1:0], link.cal_busy};
		if (r.cal_s[1] == r.cal_s[2]) begin
			n.cal_f = r.cal_s[2];
		end
		// Read data captured in the setup cycle
		if (psel && !penable) begin
			n.rd = 32'h0;
			if (paddr == HOST_CMD) begin
				n.rd = {12'h0, r.cmd};
			end else if (paddr == HOST_STATUS) begin
				n.rd = {28'h0, r.cal_f, r.gwarn, r.refused, (r.st != H_IDLE)};
			end
		end
		// Sync reset pulse countdown
		if (r.rcnt != 8'h00) begin
			n.rcnt = r.rcnt - 8'h01;
		end
		if (wr_acc && paddr == HOST_CTRL && pwdata[0]) begin
			n.rcnt = 8'(RST_CYC); // RULE19
		end
		// Sticky flags: write one clears, set below wins
		if (wr_acc && paddr == HOST_STATUS) begin
			n.refused = r.refused && !pwdata[ST_REFUSED];
			n.gwarn   = r.gwarn && !pwdata[ST_GAIN_WARN];
		end
		if (wr_acc && paddr == HOST_CMD) begin
			// Fill unused low bits with ones
			unique case (pwdata[19:16])
				REG_GAIN, REG_FINE: d = pwdata[15:0] | ONES_VAL; // RULE4
				REG_COARSE: d = pwdata[15:0] | ONES_COARSE; // RULE4
				REG_BUFFER: d = pwdata[15:0] | ONES_BUFFER; // RULE4
				REG_CONFIG: d = pwdata[15:0] | CFG_FIXED | (16'(r.pa_on) << TRIM_BIT); // RULE9
				default: d = pwdata[15:0];
			endcase
			if (r.st != H_IDLE) begin
				n.refused = 1'b1;
			end else if (pwdata[19:16] == REG_COARSE && pwdata[PA_ON_BIT] && !r.trim) begin
				n.refused = 1'b1; // RULE9
			end else begin
				n.cmd = {pwdata[19:16], d};
				n.sh  = {FRAME_HDR, pwdata[19:16], d};
				n.st  = H_WAIT;
				if (pwdata[19:16] == REG_GAIN && (d[15:7] < GAIN_REC_LO || d[15:7] > GAIN_REC_HI)) begin
					n.gwarn = 1'b1; // RULE2
				end
				if (pwdata[19:16] == REG_COARSE) begin
					n.pa_on = pwdata[PA_ON_BIT];
				end
				if (pwdata[19:16] == REG_CONFIG) begin
					n.trim = d[TRIM_BIT];
					n.diff = d[DIFF_BIT];
				end
			end
		end
		unique case (r.st)
			// Hold off while calibration runs
			H_WAIT: begin
				if (!r.cal_f) begin
					n.st   = H_SHIFT; // RULE21
					n.cs_n = 1'b0;
					n.div  = 8'h00;
					n.nbit = 6'h00;
				end
			end
			// Toggle clock, change data after falling edge
			H_SHIFT: begin
				n.div = r.div + 8'h01;
				if (r.div == 8'(HALF_CYC - 1)) begin
					n.div  = 8'h00;
					n.sclk = !r.sclk;
					if (r.sclk) begin
						n.nbit = r.nbit + 6'h01;
						n.sh   = {r.sh[30:0], 1'b0};
						if (r.nbit == LAST_BIT) begin
							n.cs_n = 1'b1;
							n.st   = H_IDLE;
						end
					end
				end
			end
			default: begin
				n.sclk = 1'b0;
			end
		endcase
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= '{st: H_IDLE, cs_n: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end
endmodule
`default_nettype wire

// ==== verification/aecr_link_sva.sv ====
// Purpose: Checks on the serial link between host end and device end
// Assumes: Both ends run on the one 40 MHz clock
// Notes:   Sees only the link signals, clock and reset
`timescale 1ns/1ps
`default_nettype none
module aecr_link_sva #(
	parameter int HALF_CYC = 4,
	parameter int RST_CYC  = 4
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic sclk,
	input wire logic scs_n,
	input wire logic sdata,
	input wire logic cal_busy,
	input wire logic sync_rst_se,
	input wire logic sync_rst_diff
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic       sclk_q_r;  // Serial clock one cycle back
	logic [7:0] hi_cnt_r;  // Cycles the serial clock has been high
	logic [7:0] lo_cnt_r;  // Cycles the serial clock has been low
	logic [5:0] bit_cnt_r; // Serial clock rises in this frame
	logic [7:0] rst_cnt_r; // Cycles a sync reset line has been high

	// Count widths and bits; cleared by reset
	always_ff @(posedge clock) begin
		if (srst) begin
			sclk_q_r  <= 1'b0;
			hi_cnt_r  <= 8'h00;
			lo_cnt_r  <= 8'h00;
			bit_cnt_r <= 6'h00;
			rst_cnt_r <= 8'h00;
		end else begin
			sclk_q_r  <= sclk;
			hi_cnt_r  <= sclk ? hi_cnt_r + 8'h01 : 8'h00;
			lo_cnt_r  <= sclk ? 8'h00 : lo_cnt_r + 8'h01;
			bit_cnt_r <= scs_n ? 6'h00 : bit_cnt_r + {5'h00, sclk & ~sclk_q_r};
			rst_cnt_r <= (sync_rst_se | sync_rst_diff) ? rst_cnt_r + 8'h01 : 8'h00;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	idle_clock_low_a: assert property (scs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	sclk_high_width_a: assert property ($fell(sclk) |-> hi_cnt_r == HALF_CYC)
		else $error("serial clock high half has wrong length");
	sclk_low_width_a: assert property ($rose(sclk) && bit_cnt_r != 6'h00 |-> lo_cnt_r == HALF_CYC)
		else $error("serial clock low half has wrong length");
	data_steady_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("serial data moved while clock high");
	frame_length_a: assert property ($rose(scs_n) |-> bit_cnt_r == 6'h20)
		else $error("frame closed without 32 bits");
	cal_quiet_a: assert property ($fell(scs_n) |-> !cal_busy && !$past(cal_busy))
		else $error("frame started during calibration");
	one_reset_line_a: assert property (!(sync_rst_se && sync_rst_diff))
		else $error("both sync reset lines driven");
	sync_pulse_width_a: assert property ($fell(sync_rst_se || sync_rst_diff) |-> rst_cnt_r >= RST_CYC)
		else $error("sync reset pulse too short");
endmodule
`default_nettype wire

// ==== verification/test_adc_extended_control_regs.sv ====
// Purpose: Self-checking bench for host and device ends joined by the link
// Assumes: APB host with no wait states, link clock made by the host
// Notes:   Expected values come from the field layout and package constants
`timescale 1ns/1ps
`default_nettype none
module test_adc_extended_control_regs;
	import aecr_pkg::*;
	logic        clock, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        ext_mode, cal_active, capture_enable, full_clear, buffer_empty_flag;
	logic [7:0]  converter_data, pattern_data, capture_data;
	logic [8:0]  gain_code, fine_delay;
	logic [3:0]  coarse_delay_steps;
	logic [1:0]  buffer_depth_select;
	logic [12:0] buffer_depth_bytes;
	logic        phase_adjust_on, slow_sample_clock_mode, diff_sync_reset_select, termination_trim_off;
	logic        stop_when_full, dual_port_output, pattern_generator_on, capture_write;
	logic        buffer_full_flag, out_of_range, sampling_held, sampling_resync, recal_request;
	logic        sclk_q, saw_diff;   // Monitor state
	logic [31:0] frame_sh;           // Bits seen in the last frame
	logic [4:0]  mon;                // Flags a wait may poll
	int          resyncs, writes, cycles, err_count, checks;

	// ----------------------------------------
	// Ends, link and checker
	// ----------------------------------------
	aecr_link_if link_bus ();
	aecr_host #(.HALF_CYC(SCLK_HALF_CYC), .RST_CYC(SYNC_RST_CYC)) i_aecr_host (.clock, .srst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link_bus));
	aecr_device i_aecr_device (.clock, .srst, .ext_mode, .cal_active, .capture_enable, .full_clear,
		.buffer_empty_flag, .converter_data, .pattern_data, .link(link_bus), .gain_code, .fine_delay,
		.coarse_delay_steps, .phase_adjust_on, .slow_sample_clock_mode, .diff_sync_reset_select,
		.termination_trim_off, .buffer_depth_select, .buffer_depth_bytes, .stop_when_full, .dual_port_output,
		.pattern_generator_on, .capture_data, .capture_write, .capture_addr(), .buffer_full_flag,
		.out_of_range, .sampling_held, .sampling_resync, .recal_request);
	aecr_link_sva #(.HALF_CYC(SCLK_HALF_CYC), .RST_CYC(SYNC_RST_CYC)) i_aecr_link_sva (.clock(clock),
		.srst(srst), .sclk(link_bus.sclk), .scs_n(link_bus.scs_n), .sdata(link_bus.sdata),
		.cal_busy(link_bus.cal_busy), .sync_rst_se(link_bus.sync_rst_se), .sync_rst_diff(link_bus.sync_rst_diff));

	assign mon = {capture_write, buffer_full_flag, out_of_range, sampling_held, 1'b0};

	// Clock at 40 MHz
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Link monitor, event counters and hang guard
	always @(posedge clock) begin
		sclk_q <= link_bus.sclk;
		if (!link_bus.scs_n && link_bus.sclk && !sclk_q) begin
			frame_sh <= {frame_sh[30:0], link_bus.sdata};
		end
		saw_diff <= saw_diff | link_bus.sync_rst_diff;
		resyncs <= resyncs + int'(sampling_resync === 1'b1);
		writes <= writes + int'(capture_write === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// Poll busy until the frame is out, then let the device settle
	task automatic wait_idle();
		logic [31:0] q;
		logic        e;
		q = 32'h1;
		while (q[ST_BUSY] !== 1'b0) begin
			apb(1'b0, HOST_STATUS, 32'h0, q, e);
		end
		repeat (8) @(posedge clock);
	endtask

	task automatic send(input logic [3:0] a, input logic [15:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, HOST_CMD, {12'h000, a, d}, q, e);
		wait_idle();
	endtask

	// Bounded wait for a monitored flag to reach a level
	task automatic wait_on(input string name, input int idx, input logic v, input int lim);
		int n;
		n = 0;
		while (mon[idx] !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk(name, v, mon[idx]);
	endtask

	task automatic final_report();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic        e;
		int          n;
		{srst, ext_mode, buffer_empty_flag} = 3'h7;
		{psel, penable, pwrite, cal_active, capture_enable, full_clear, saw_diff, sclk_q} = 8'h00;
		{paddr, pwdata, frame_sh} = 72'h0;
		converter_data = 8'h33;
		pattern_data = 8'ha5;
		{resyncs, writes, cycles, err_count, checks} = '0;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		chk("gain", GAIN_POR, gain_code);
		chk("fine", FINE_POR, fine_delay);
		chk("steps", STEP_POR, coarse_delay_steps);
		chk("pa_on", 0, phase_adjust_on);
		chk("slow", 0, slow_sample_clock_mode);
		chk("diff", 0, diff_sync_reset_select);
		chk("depth", DEPTH_POR, buffer_depth_select);
		chk("stop", 1, stop_when_full);
		chk("dual", 0, dual_port_output);
		chk("pat", 0, pattern_generator_on);
		// Gain write held off by calibration
		cal_active <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b1, HOST_CMD, {12'h000, REG_GAIN, 16'h6000}, q, e);
		repeat (30) @(posedge clock);
		chk("scs_n", 1, link_bus.scs_n);
		cal_active <= 1'b0;
		wait_idle();
		chk("frame", {FRAME_HDR, REG_GAIN, 16'h607f}, frame_sh);
		chk("gain", 9'h0c0, gain_code);
		chk("recal", 0, recal_request);
		send(REG_GAIN, 16'hff80);
		chk("gain", 9'h1ff, gain_code);
		apb(1'b0, HOST_STATUS, 32'h0, q, e);
		chk("warn", 1, q[ST_GAIN_WARN]);
		// Phase fields, gated by the enable and by the trim bit
		send(REG_FINE, 16'hff80);
		chk("frame", {FRAME_HDR, REG_FINE, 16'hffff}, frame_sh);
		chk("fine", 0, fine_delay);
		send(REG_COARSE, 16'hd400);
		apb(1'b0, HOST_STATUS, 32'h0, q, e);
		chk("refused", 1, q[ST_REFUSED]);
		chk("pa_on", 0, phase_adjust_on);
		send(REG_CONFIG, 16'h2000);
		chk("frame", {FRAME_HDR, REG_CONFIG, 16'ha2ff}, frame_sh);
		chk("trim", 1, termination_trim_off);
		send(REG_COARSE, 16'hd400);
		chk("frame", {FRAME_HDR, REG_COARSE, 16'hd7ff}, frame_sh);
		chk("pa_on", 1, phase_adjust_on);
		chk("steps", 4'ha, coarse_delay_steps);
		chk("fine", 9'h1ff, fine_delay);
		chk("slow", 1, slow_sample_clock_mode);
		// Every depth code, with stop and dual bits varied
		for (int i = 0; i < 4; i++) begin
			send(REG_BUFFER, {i[1:0], i[0], i[1], 12'h000});
			chk("depth", i, buffer_depth_select);
			chk("bytes", DEPTH_BASE << i, buffer_depth_bytes);
			chk("stop", i & 1, stop_when_full);
			chk("dual", i >> 1, dual_port_output);
		end
		chk("frame", {FRAME_HDR, REG_BUFFER, 16'hf7ff}, frame_sh);
		// Fill 512 bytes with auto-stop, then overwrite
		send(REG_BUFFER, 16'h2000);
		n = writes;
		capture_enable <= 1'b1;
		wait_on("cap_wr", 4, 1'b1, 50);
		chk("cap", 8'h33, capture_data);
		wait_on("full", 3, 1'b1, 2000);
		repeat (20) @(posedge clock);
		chk("stopped", DEPTH_BASE, writes - n);
		send(REG_BUFFER, 16'h0000);
		n = writes;
		repeat (20) @(posedge clock);
		chk("overwrite", 1, writes > n);
		// Test pattern drives data and overrange until empty
		buffer_empty_flag <= 1'b0;
		send(REG_BUFFER, 16'h1800);
		wait_on("cap_wr", 4, 1'b1, 50);
		chk("pat_data", 8'ha5, capture_data);
		chk("oor", 1, out_of_range);
		buffer_empty_flag <= 1'b1;
		wait_on("oor", 2, 1'b0, 20);
		// Normal mode shows defaults
		ext_mode <= 1'b0;
		repeat (3) @(posedge clock);
		chk("gain", GAIN_POR, gain_code);
		chk("depth", DEPTH_POR, buffer_depth_select);
		ext_mode <= 1'b1;
		// Sync reset on each input
		n = resyncs;
		apb(1'b1, HOST_CTRL, 32'h1, q, e);
		wait_on("held", 1, 1'b1, 20);
		wait_on("held", 1, 1'b0, 40);
		repeat (3) @(posedge clock);
		chk("resync", n + 1, resyncs);
		chk("diff_line", 0, saw_diff);
		send(REG_CONFIG, 16'h6000);
		chk("diff", 1, diff_sync_reset_select);
		apb(1'b1, HOST_CTRL, 32'h1, q, e);
		wait_on("held", 1, 1'b1, 20);
		chk("diff_line", 1, saw_diff);
		// Unmapped APB address
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("slverr", 1, e);
		chk("rdata", 0, q);
		final_report();
	end
endmodule
`default_nettype wire
